/* mear_defines.vh */
`ifndef MEAR_DEFINES_VH
`define MEAR_DEFINES_VH

// Byte addresses of the advanced register set
`define MEAR_ADDR_STATUS     8'hf0
`define MEAR_ADDR_WINCTL     8'hf2
`define MEAR_ADDR_RATE_HI    8'hf3
`define MEAR_ADDR_RATE_LO    8'hf4
`define MEAR_ADDR_AVG        8'hf5
`define MEAR_ADDR_DEB_TIME   8'hf6
`define MEAR_ADDR_DEB_BATCH  8'hf7
`define MEAR_ADDR_TRN_SENS   8'hf8
`define MEAR_ADDR_NSE_SENS   8'hf9
`define MEAR_ADDR_SIG_HI     8'hfa
`define MEAR_ADDR_SIG_LO     8'hfb
`define MEAR_ADDR_DC_HI      8'hfc
`define MEAR_ADDR_DC_LO      8'hfd

// Status register bit positions
`define MEAR_BIT_REFRESH     4
`define MEAR_BIT_NEWSAMP     3
`define MEAR_BIT_ORIGIN      2
`define MEAR_BIT_NOISE       1
`define MEAR_BIT_TRANS       0

// Window control field positions
`define MEAR_LOCK_HI         7
`define MEAR_LOCK_LO         5
`define MEAR_WSIZE_HI        4
`define MEAR_WSIZE_LO        3
`define MEAR_URATE_HI        2
`define MEAR_URATE_LO        0

// Window size codes
`define MEAR_WSIZE_RSVD      2'h0
`define MEAR_WSIZE_SMALL     2'h1
`define MEAR_WSIZE_MEDIUM    2'h2
`define MEAR_WSIZE_LARGE     2'h3

// Limit update period: base samples plus rate times step
`define MEAR_UPD_BASE        5'h04
`define MEAR_UPD_STEP        5'h02

// Reset values
`define MEAR_RST_BYTE        8'h00
`define MEAR_RST_WORD        16'h0000
`define MEAR_RST_CNT         5'h00

`endif

/* mear_regs.v */
// Summary of operation
// - Engine logic never writes configuration registers; software must load them.
// - Init run with refresh bit set fires a fast buffer fill request.
// - Setting refresh bit clears motion history; buffers refill at the next init run.
// - After wake-up software sets refresh, runs init, then detects awhile.
// - New-sample flag sets whenever a fresh sample lands in signal pair.
// - Origin bit follows each motion event: 0 normal, 1 extended detector.
// - Noise flag sets on detected noise; software clears it.
// - Transient flag sets on detected transient; software clears it.
// - Lock level bits 7:5 give minimum slope accepted as motion.
// - Window size bits 4:3 select reserved, small, medium or large.
// - Limits recompute every four plus twice update-rate samples.
// - Sixteen-bit read-only processing headroom at F3h and F4h.
// - Byte at F5h sets averaging of incoming samples.
// - Byte at F6h sets motion debounce duration.
// - Byte at F7h sets out-of-window samples needed per debounce count.
// - Byte at F8h sets transient detection sensitivity.
// - Byte at F9h sets noise detection sensitivity.
// - Sixteen-bit read-only sensor sample at FAh and FBh.
`include "mear_defines.vh"

module mear_regs (
  input  wire        sys_clk,          // System clock
  input  wire        reset_n,          // Synchronous reset, low active
  input  wire [7:0]  reg_addr,         // Register byte address
  input  wire [7:0]  reg_wdata,        // Write data
  input  wire        reg_wr,           // Write strobe
  input  wire        reg_rd,           // Read strobe
  output reg  [7:0]  reg_rdata,        // Read data, cycle after strobe
  input  wire        init_start,       // Engine init routine pulse
  input  wire        sample_valid,     // Fresh sensor sample pulse
  input  wire [15:0] sample_value,     // Fresh sensor sample
  input  wire        motion_event,     // Motion detected pulse
  input  wire        motion_extended,  // Event came from extended detector
  input  wire        noise_event,      // Noise detected pulse
  input  wire        transient_event,  // Transient detected pulse
  input  wire        dc_valid,         // New DC level pulse
  input  wire [15:0] dc_value,         // New DC level
  input  wire [15:0] headroom_value,   // Processing headroom from engine
  output reg         fast_fill_r,      // Fast buffer fill request pulse
  output reg         history_clear_r,  // Motion history reset pulse
  output reg         limit_update_r,   // Control limit recompute pulse
  output reg         slope_ok_r,       // Last sample slope meets lock level
  output reg  [2:0]  lock_level_r,     // Lock level field
  output reg  [1:0]  window_size_r,    // Window size field
  output reg         window_valid_r,   // Window size not reserved
  output reg  [2:0]  update_rate_r,    // Update rate field
  output reg  [7:0]  averaging_r,      // Averaging amount
  output reg  [7:0]  debounce_time_r,  // Debounce duration
  output reg  [7:0]  debounce_batch_r, // Debounce batch mask
  output reg  [6:0]  trans_sens_r,     // Transient sensitivity
  output reg  [6:0]  noise_sens_r      // Noise sensitivity
);

  // Status flags
  reg        refresh_r;
  reg        newsamp_r;
  reg        origin_r;
  reg        noise_r;
  reg        trans_r;
  reg        refresh_nxt;
  reg        newsamp_nxt;
  reg        noise_nxt;
  reg        trans_nxt;

  // Engine-side data words
  reg [15:0] sample_r;
  reg [15:0] dc_r;
  reg [15:0] headroom_r;

  // Limit update sample counter
  reg [4:0]  upd_cnt_r;
  reg [4:0]  upd_cnt_nxt;
  reg        upd_fire;
  wire [4:0] upd_period;

  // Slope check
  reg [15:0] slope_mag;

  // Read mux
  reg [7:0]  rd_nxt;

  wire       wr_status;
  wire       wr_winctl;

  assign wr_status = reg_wr && (reg_addr == `MEAR_ADDR_STATUS);
  assign wr_winctl = reg_wr && (reg_addr == `MEAR_ADDR_WINCTL);

  // Period in samples from update rate
  assign upd_period = `MEAR_UPD_BASE
                    + ({2'h0, update_rate_r} * `MEAR_UPD_STEP);

  // Flag next values; a hardware set wins over a software clear
  always @*
  begin
    refresh_nxt = refresh_r;
    newsamp_nxt = newsamp_r;
    noise_nxt   = noise_r;
    trans_nxt   = trans_r;
    if (wr_status)
    begin
      refresh_nxt = reg_wdata[`MEAR_BIT_REFRESH];
      newsamp_nxt = reg_wdata[`MEAR_BIT_NEWSAMP];
      noise_nxt   = reg_wdata[`MEAR_BIT_NOISE];
      trans_nxt   = reg_wdata[`MEAR_BIT_TRANS];
    end
    if (sample_valid)
      newsamp_nxt = 1'b1;
    if (noise_event)
      noise_nxt = 1'b1;
    if (transient_event)
      trans_nxt = 1'b1;
  end

  // Status register and pulses derived from it
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      refresh_r       <= 1'b0;
      newsamp_r       <= 1'b0;
      origin_r        <= 1'b0;
      noise_r         <= 1'b0;
      trans_r         <= 1'b0;
      fast_fill_r     <= 1'b0;
      history_clear_r <= 1'b0;
    end
    else
    begin
      refresh_r <= refresh_nxt;
      newsamp_r <= newsamp_nxt;
      noise_r   <= noise_nxt;
      trans_r   <= trans_nxt;
      if (motion_event)
        origin_r <= motion_extended;
      // Init with refresh armed asks for fast fill
      fast_fill_r <= init_start && refresh_r;
      // Setting refresh drops motion history
      history_clear_r <= wr_status && !refresh_r
                      && reg_wdata[`MEAR_BIT_REFRESH];
    end
  end

  // Window control register and its decoded fields
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lock_level_r   <= 3'h0;
      window_size_r  <= `MEAR_WSIZE_RSVD;
      window_valid_r <= 1'b0;
      update_rate_r  <= 3'h0;
    end
    else if (wr_winctl)
    begin
      lock_level_r  <= reg_wdata[`MEAR_LOCK_HI:`MEAR_LOCK_LO];
      window_size_r <= reg_wdata[`MEAR_WSIZE_HI:`MEAR_WSIZE_LO];
      window_valid_r <= (reg_wdata[`MEAR_WSIZE_HI:`MEAR_WSIZE_LO]
                         != `MEAR_WSIZE_RSVD);
      update_rate_r <= reg_wdata[`MEAR_URATE_HI:`MEAR_URATE_LO];
    end
  end

  // Plain configuration bytes, written only by software
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      averaging_r      <= `MEAR_RST_BYTE;
      debounce_time_r  <= `MEAR_RST_BYTE;
      debounce_batch_r <= `MEAR_RST_BYTE;
      trans_sens_r     <= 7'h00;
      noise_sens_r     <= 7'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MEAR_ADDR_AVG:       averaging_r      <= reg_wdata;
        `MEAR_ADDR_DEB_TIME:  debounce_time_r  <= reg_wdata;
        `MEAR_ADDR_DEB_BATCH: debounce_batch_r <= reg_wdata;
        `MEAR_ADDR_TRN_SENS:  trans_sens_r     <= reg_wdata[6:0];
        `MEAR_ADDR_NSE_SENS:  noise_sens_r     <= reg_wdata[6:0];
        default:
        begin
        end
      endcase
    end
  end

  // Sample and DC words captured on their strobes, headroom every cycle
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sample_r   <= `MEAR_RST_WORD;
      dc_r       <= `MEAR_RST_WORD;
      headroom_r <= `MEAR_RST_WORD;
    end
    else
    begin
      if (sample_valid)
        sample_r <= sample_value;
      if (dc_valid)
        dc_r <= dc_value;
      headroom_r <= headroom_value;
    end
  end

  // Slope between successive samples
  always @*
  begin
    if (sample_value >= sample_r)
      slope_mag = sample_value - sample_r;
    else
      slope_mag = sample_r - sample_value;
  end

  // Slope qualification against lock level
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      slope_ok_r <= 1'b0;
    else if (sample_valid)
      slope_ok_r <= (slope_mag >= {13'h0000, lock_level_r});
  end

  // Sample counter next state
  always @*
  begin
    upd_fire    = 1'b0;
    upd_cnt_nxt = upd_cnt_r;
    if (sample_valid)
    begin
      if ((upd_cnt_r + 5'h01) >= upd_period)
      begin
        upd_fire    = 1'b1;
        upd_cnt_nxt = `MEAR_RST_CNT;
      end
      else
        upd_cnt_nxt = upd_cnt_r + 5'h01;
    end
    if (history_clear_r)
    begin
      upd_fire    = 1'b0;
      upd_cnt_nxt = `MEAR_RST_CNT;
    end
  end

  // Limit update counter and pulse
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      upd_cnt_r      <= `MEAR_RST_CNT;
      limit_update_r <= 1'b0;
    end
    else
    begin
      upd_cnt_r      <= upd_cnt_nxt;
      limit_update_r <= upd_fire;
    end
  end

  // Read data select; unmapped bytes read zero
  always @*
  begin
    case (reg_addr)
      `MEAR_ADDR_STATUS:    rd_nxt = {3'h0, refresh_r, newsamp_r,
                                      origin_r, noise_r, trans_r};
      `MEAR_ADDR_WINCTL:    rd_nxt = {lock_level_r, window_size_r,
                                      update_rate_r};
      `MEAR_ADDR_RATE_HI:   rd_nxt = headroom_r[15:8];
      `MEAR_ADDR_RATE_LO:   rd_nxt = headroom_r[7:0];
      `MEAR_ADDR_AVG:       rd_nxt = averaging_r;
      `MEAR_ADDR_DEB_TIME:  rd_nxt = debounce_time_r;
      `MEAR_ADDR_DEB_BATCH: rd_nxt = debounce_batch_r;
      `MEAR_ADDR_TRN_SENS:  rd_nxt = {1'b0, trans_sens_r};
      `MEAR_ADDR_NSE_SENS:  rd_nxt = {1'b0, noise_sens_r};
      `MEAR_ADDR_SIG_HI:    rd_nxt = sample_r[15:8];
      `MEAR_ADDR_SIG_LO:    rd_nxt = sample_r[7:0];
      `MEAR_ADDR_DC_HI:     rd_nxt = dc_r[15:8];
      `MEAR_ADDR_DC_LO:     rd_nxt = dc_r[7:0];
      default:              rd_nxt = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
    else
      reg_rdata <= 8'h00;
  end

endmodule // mear_regs

/* mear_regs_checker.sv */
`include "mear_defines.vh"
module mear_regs_checker (
  input wire logic       sys_clk,         // Clock
  input wire logic       reset_n,         // Reset
  input wire logic [7:0] reg_addr,        // Address
  input wire logic [7:0] reg_wdata,       // Write data
  input wire logic       reg_wr,          // Write strobe
  input wire logic       reg_rd,          // Read strobe
  input wire logic [7:0] reg_rdata,       // Read data
  input wire logic       init_start,      // Init pulse
  input wire logic       sample_valid,    // Sample pulse
  input wire logic       fast_fill_r,     // Fill pulse
  input wire logic       history_clear_r, // Clear pulse
  input wire logic       limit_update_r,  // Limit pulse
  input wire logic [2:0] lock_level_r,    // Lock field
  input wire logic [1:0] window_size_r,   // Size field
  input wire logic       window_valid_r   // Size usable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       refresh_m; // Shadow of the refresh bit
  logic [7:0] wd_q;      // Write data of last cycle
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Track the refresh bit from software writes
  always_ff @(posedge sys_clk)
  begin
    wd_q <= reg_wdata;
    if (!reset_n)
      refresh_m <= 1'b0;
    else if (reg_wr && reg_addr == `MEAR_ADDR_STATUS)
      refresh_m <= reg_wdata[4];
  end
  chk_fill_on_init: assert property (init_start && refresh_m |=> fast_fill_r)
    else $error("fill request missing after init");
  chk_fill_cause: assert property (fast_fill_r |-> $past(init_start))
    else $error("fill request without init");
  chk_hist_clear: assert property (reg_wr && reg_addr == `MEAR_ADDR_STATUS
    && reg_wdata[4] && !refresh_m |=> history_clear_r) else $error("history clear missing");
  chk_clear_cause: assert property (history_clear_r |-> $past(reg_wr))
    else $error("history clear without write");
  chk_status_rsvd: assert property (reg_rd && reg_addr == `MEAR_ADDR_STATUS
    |=> reg_rdata[7:5] == 3'h0) else $error("status reserved bits not zero");
  chk_lock_copy: assert property (reg_wr && reg_addr == `MEAR_ADDR_WINCTL
    |=> lock_level_r == wd_q[7:5] && window_size_r == wd_q[4:3]) else $error("lock copy");
  chk_window_valid: assert property (window_valid_r == (window_size_r != 2'h0))
    else $error("window valid wrong");
  chk_limit_cause: assert property (limit_update_r |-> $past(sample_valid))
    else $error("limit update without sample");
  cover property (fast_fill_r);
  cover property (history_clear_r);
  cover property (limit_update_r);
endmodule // mear_regs_checker

/* mear_regs_bench.sv */
`include "mear_defines.vh"
module mear_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic init_start = 1'b0, sample_valid = 1'b0, motion_event = 1'b0, motion_extended = 1'b0;
  logic noise_event = 1'b0, transient_event = 1'b0, dc_valid = 1'b0;
  logic [15:0] sample_value = 16'h0000, dc_value = 16'h0000, headroom_value = 16'hbeef;
  logic fast_fill_r, history_clear_r, limit_update_r, slope_ok_r, window_valid_r;
  logic [2:0] lock_level_r, update_rate_r;
  logic [1:0] window_size_r;
  logic [7:0] averaging_r, debounce_time_r, debounce_batch_r;
  logic [6:0] trans_sens_r, noise_sens_r;
  int n_errors = 0, compares = 0, n;
  // Address, write data, expected read back
  logic [23:0] rows [10] = '{24'hf0e400, 24'hf2a5a5, 24'hf53c3c, 24'hf68181, 24'hf70f0f,
    24'hf8ff7f, 24'hf9ff7f, 24'hf311be, 24'hf422ef, 24'he05500};
  mear_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .init_start(init_start), .sample_valid(sample_valid), .sample_value(sample_value),
    .motion_event(motion_event), .motion_extended(motion_extended),
    .noise_event(noise_event), .transient_event(transient_event), .dc_valid(dc_valid),
    .dc_value(dc_value), .headroom_value(headroom_value), .fast_fill_r(fast_fill_r),
    .history_clear_r(history_clear_r), .limit_update_r(limit_update_r),
    .slope_ok_r(slope_ok_r), .lock_level_r(lock_level_r), .window_size_r(window_size_r),
    .window_valid_r(window_valid_r), .update_rate_r(update_rate_r),
    .averaging_r(averaging_r), .debounce_time_r(debounce_time_r),
    .debounce_batch_r(debounce_batch_r), .trans_sens_r(trans_sens_r),
    .noise_sens_r(noise_sens_r));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Engine pulses: init, sample, motion, noise, transient, dc
  task automatic ev(input logic [5:0] m, input logic [15:0] d);
    @(posedge sys_clk);
    {init_start, sample_valid, motion_event, noise_event, transient_event, dc_valid} <= m;
    sample_value <= d;
    dc_value <= d;
    motion_extended <= d[0];
    @(posedge sys_clk);
    {init_start, sample_valid, motion_event, noise_event, transient_event, dc_valid} <= 6'h00;
    #1;
  endtask
  task automatic finish_test;
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog for a hung run
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`MEAR_ADDR_WINCTL, 8'h00);
    chk({fast_fill_r, history_clear_r, limit_update_r, averaging_r}, 16'h0000);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({lock_level_r, window_size_r, window_valid_r, update_rate_r}, 16'h0145);
    chk({averaging_r, debounce_time_r}, 16'h3c81);
    chk({debounce_batch_r, 1'b0, trans_sens_r}, 16'h0f7f);
    chk(noise_sens_r, 16'h007f);
    for (int w = 0; w < 4; w++)
    begin
      wr(`MEAR_ADDR_WINCTL, {3'h0, w[1:0], 3'h0});
      chk({window_size_r, window_valid_r}, {w[1:0], w != 0});
    end
    // Fresh sample, flag stays until software clears it
    ev(6'h10, 16'h1234);
    rd(`MEAR_ADDR_STATUS, 8'h08);
    rd(`MEAR_ADDR_SIG_HI, 8'h12);
    rd(`MEAR_ADDR_SIG_LO, 8'h34);
    rd(`MEAR_ADDR_STATUS, 8'h08);
    wr(`MEAR_ADDR_STATUS, 8'h00);
    rd(`MEAR_ADDR_STATUS, 8'h00);
    // Origin follows events and ignores writes
    ev(6'h08, 16'h0001);
    wr(`MEAR_ADDR_STATUS, 8'h00);
    rd(`MEAR_ADDR_STATUS, 8'h04);
    ev(6'h04, 16'h0000);
    ev(6'h02, 16'h0000);
    rd(`MEAR_ADDR_STATUS, 8'h07);
    ev(6'h08, 16'h0000);
    wr(`MEAR_ADDR_STATUS, 8'h04);
    rd(`MEAR_ADDR_STATUS, 8'h00);
    ev(6'h01, 16'habcd);
    rd(`MEAR_ADDR_DC_HI, 8'hab);
    rd(`MEAR_ADDR_DC_LO, 8'hcd);
    // Refresh bit: history clear on rise, fast fill at init
    ev(6'h20, 16'h0000);
    chk(fast_fill_r, 16'h0000);
    wr(`MEAR_ADDR_STATUS, 8'h10);
    chk(history_clear_r, 16'h0001);
    ev(6'h20, 16'h0000);
    chk(fast_fill_r, 16'h0001);
    wr(`MEAR_ADDR_STATUS, 8'h10);
    chk(history_clear_r, 16'h0000);
    // Limit period at the extreme rates, slope against lock level
    for (int r = 0; r < 8; r += 7)
    begin
      wr(`MEAR_ADDR_STATUS, 8'h00);
      wr(`MEAR_ADDR_STATUS, 8'h10);
      wr(`MEAR_ADDR_WINCTL, (r == 0) ? 8'h08 : 8'hef);
      n = 4 + 2 * r;
      for (int i = 0; i < n; i++)
      begin
        ev(6'h10, i[15:0]);
        chk({slope_ok_r, limit_update_r}, {r == 0, i == n - 1});
      end
    end
    // Engine activity has left the configuration bytes alone
    chk({averaging_r, debounce_time_r}, 16'h3c81);
    // Event and software clear in one cycle: the hardware set wins
    @(posedge sys_clk);
    {noise_event, transient_event, reg_wr, reg_addr, reg_wdata} <=
      {2'b11, 1'b1, `MEAR_ADDR_STATUS, 8'h00};
    @(posedge sys_clk);
    {noise_event, transient_event, reg_wr} <= 3'h0;
    #1;
    rd(`MEAR_ADDR_STATUS, 8'h03);
    // Mid-run reset, then headroom must follow its input every cycle
    @(posedge sys_clk);
    reset_n <= 1'b0;
    headroom_value <= 16'h1357;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 chk({averaging_r, lock_level_r, window_size_r, slope_ok_r}, 16'h0000);
    rd(`MEAR_ADDR_STATUS, 8'h00);
    rd(`MEAR_ADDR_RATE_HI, 8'h13);
    rd(`MEAR_ADDR_RATE_LO, 8'h57);
    finish_test();
  end
endmodule // mear_regs_bench
bind mear_regs mear_regs_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .init_start(init_start), .sample_valid(sample_valid),
  .fast_fill_r(fast_fill_r), .history_clear_r(history_clear_r),
  .limit_update_r(limit_update_r), .lock_level_r(lock_level_r),
  .window_size_r(window_size_r), .window_valid_r(window_valid_r));
